/* logic/ctot_pkg.sv */
/*
  Package for the core timing and offset trim register bank: byte addresses,
  field layout, reset of the reserved nibble, and the carrier structs.
  Assumes a byte-wide register port with 12-bit byte addresses.
*/
package ctot_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;

  // Byte addresses of the bank
  localparam logic [11:0] TIMING_TRIM_SPARE_FOR_B_DUAL_ADDR = 12'h088;
  localparam logic [11:0] TIMING_TRIM_CORE_B_DUAL_ADDR      = 12'h089;
  localparam logic [11:0] OFFSET_TRIM_CORE_A_INPUT_A_ADDR   = 12'h08A;
  localparam logic [11:0] OFFSET_TRIM_CORE_A_INPUT_B_ADDR   = 12'h08C;
  localparam logic [11:0] OFFSET_TRIM_SPARE_INPUT_A_ADDR    = 12'h08E;

  // Offset register field layout
  localparam int unsigned OFFSET_VALUE_W   = 12;
  localparam int unsigned OFFSET_RSVD_LSB  = 12;
  localparam int unsigned OFFSET_RSVD_W    = 4;
  localparam logic [3:0]  OFFSET_RSVD_RST  = 4'h0;
  localparam int unsigned NUM_OFFSET_REGS  = 3;

  // Register port request from software
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } ctot_req_s;

  // Trim values presented to the converter cores
  typedef struct packed {
    logic [7:0]  timing_spare_for_b_dual;
    logic [7:0]  timing_core_b_dual;
    logic [11:0] offset_core_a_input_a;
    logic [11:0] offset_core_a_input_b;
    logic [11:0] offset_spare_input_a;
  } ctot_trim_s;

  // Factory fuse image loaded at reset release
  typedef struct packed {
    logic [7:0]  timing_spare_for_b_dual;
    logic [7:0]  timing_core_b_dual;
    logic [11:0] offset_core_a_input_a;
    logic [11:0] offset_core_a_input_b;
    logic [11:0] offset_spare_input_a;
  } ctot_fuse_s;

endpackage

/* logic/ctot_regs.sv */
/*
  Core timing and offset trim register bank.
  Holds two byte-wide timing trims and three 16-bit offset trims, loaded from
  the factory fuse image after reset, readable and writable by software.
  Assumes the fuse image is static on the system clock, and that software
  keeps the calibration-state access restrictions itself.
*/
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

module ctot_regs
  import ctot_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 sys_rst_i,
  // Register port
  input  wire ctot_pkg::ctot_req_s  req_i,
  output logic [7:0]                rdata_o,
  // Factory trim image and operating mode
  input  wire ctot_pkg::ctot_fuse_s fuse_i,
  input  wire logic                 dual_channel_i,
  // Trims to the converter cores
  output ctot_pkg::ctot_trim_s      trim_o,
  output logic [7:0]                spare_timing_o,
  output logic [7:0]                core_b_timing_o,
  output logic                      trim_loaded_o
);
  import ctot_pkg::*;

  logic [7:0]  tim_spare_q, tim_b_q;
  logic [15:0] ofs_q [NUM_OFFSET_REGS];
  logic        loaded_q;
  logic [7:0]  rdata_q;

  function automatic logic [11:0] ofs_base(input int unsigned idx);
    case (idx)
      0:       ofs_base = OFFSET_TRIM_CORE_A_INPUT_A_ADDR;
      1:       ofs_base = OFFSET_TRIM_CORE_A_INPUT_B_ADDR;
      default: ofs_base = OFFSET_TRIM_SPARE_INPUT_A_ADDR;
    endcase
  endfunction

  wire logic sel_tim_spare = (req_i.addr == TIMING_TRIM_SPARE_FOR_B_DUAL_ADDR);
  wire logic sel_tim_b     = (req_i.addr == TIMING_TRIM_CORE_B_DUAL_ADDR);

  wire logic [15:0] fuse_ofs [NUM_OFFSET_REGS];
  assign fuse_ofs[0] = {OFFSET_RSVD_RST, fuse_i.offset_core_a_input_a};
  assign fuse_ofs[1] = {OFFSET_RSVD_RST, fuse_i.offset_core_a_input_b};
  assign fuse_ofs[2] = {OFFSET_RSVD_RST, fuse_i.offset_spare_input_a};

  // Fuse values cannot enter under async reset; they load on the first edge after it
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      loaded_q    <= 1'b0;
      tim_spare_q <= 8'h00;
      tim_b_q     <= 8'h00;
    end else if (!loaded_q) begin
      loaded_q    <= 1'b1;
      tim_spare_q <= fuse_i.timing_spare_for_b_dual;
      tim_b_q     <= fuse_i.timing_core_b_dual;
    end else if (req_i.wr) begin
      if (sel_tim_spare) tim_spare_q <= req_i.wdata;
      if (sel_tim_b)     tim_b_q     <= req_i.wdata;
    end
  end

  wire logic [7:0] ofs_rd [NUM_OFFSET_REGS];

  genvar g;
  generate
    for (g = 0; g < NUM_OFFSET_REGS; g++) begin : g_ofs
      wire logic sel_lo = (req_i.addr == ofs_base(g));
      wire logic sel_hi = (req_i.addr == ofs_base(g) + 12'h001);
      // No interlock against calibration state: software owns that ordering
      always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          ofs_q[g] <= 16'h0000;
        end else if (!loaded_q) begin
          ofs_q[g] <= fuse_ofs[g];
        end else if (req_i.wr) begin
          if (sel_lo) ofs_q[g][7:0]  <= req_i.wdata;
          if (sel_hi) ofs_q[g][15:8] <= req_i.wdata;
        end
      end
      assign ofs_rd[g] = sel_lo ? ofs_q[g][7:0] : (sel_hi ? ofs_q[g][15:8] : 8'h00);
    end
  endgenerate

  wire logic [7:0] rd_mux = (sel_tim_spare ? tim_spare_q : 8'h00) |
                            (sel_tim_b ? tim_b_q : 8'h00) |
                            ofs_rd[0] | ofs_rd[1] | ofs_rd[2];

  // Unmapped addresses read zero; data stands only the cycle after the strobe
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) rdata_q <= 8'h00;
    else           rdata_q <= req_i.rd ? rd_mux : 8'h00;
  end

  assign rdata_o       = rdata_q;
  assign trim_loaded_o = loaded_q;

  assign trim_o.timing_spare_for_b_dual = tim_spare_q;
  assign trim_o.timing_core_b_dual      = tim_b_q;
  assign trim_o.offset_core_a_input_a   = ofs_q[0][OFFSET_VALUE_W-1:0];
  assign trim_o.offset_core_a_input_b   = ofs_q[1][OFFSET_VALUE_W-1:0];
  assign trim_o.offset_spare_input_a    = ofs_q[2][OFFSET_VALUE_W-1:0];

  // Dual mode: spare core stands in for B, B takes its own dual trim
  assign spare_timing_o  = dual_channel_i ? tim_spare_q : 8'h00;
  assign core_b_timing_o = dual_channel_i ? tim_b_q : 8'h00;

endmodule

/* test/ctot_monitor.sv */
/* Port checker for the trim bank.
   Assumes one clock, async high reset; bound to ctot_regs. */
`timescale 1ns/1ps
module ctot_monitor
  import ctot_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       sys_rst_i,
  input wire ctot_req_s  req_i,
  input wire logic [7:0] rdata_o,
  input wire ctot_fuse_s fuse_i,
  input wire logic       dual_channel_i,
  input wire ctot_trim_s trim_o,
  input wire logic [7:0] spare_timing_o,
  input wire logic [7:0] core_b_timing_o,
  input wire logic       trim_loaded_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_wr(a);
    trim_loaded_o && req_i.wr && req_i.addr == a;
  endsequence
  property p_tim; s_wr(12'h089) |=> trim_o.timing_core_b_dual == $past(req_i.wdata); endproperty
  a_tim: assert property (p_tim) else $error("timing write lost");
  property p_gate; {spare_timing_o, core_b_timing_o} == (dual_channel_i ?
    {trim_o.timing_spare_for_b_dual, trim_o.timing_core_b_dual} : 16'h0000); endproperty
  a_gate: assert property (p_gate) else $error("timing routing wrong");
  property p_load; $rose(trim_loaded_o) |-> trim_o == fuse_i; endproperty
  a_load: assert property (p_load) else $error("factory load wrong");
  property p_rd; trim_loaded_o && req_i.rd && req_i.addr == 12'h08B
    |=> rdata_o[3:0] == trim_o.offset_core_a_input_a[11:8]; endproperty
  a_rd: assert property (p_rd) else $error("upper byte read wrong");
  property p_offb; s_wr(12'h08C) |=> trim_o.offset_core_a_input_b[7:0] == $past(req_i.wdata);
  endproperty
  a_offb: assert property (p_offb) else $error("offset low byte lost");
  property p_offc; s_wr(12'h08F) |=> trim_o.offset_spare_input_a[11:8] == $past(req_i.wdata[3:0]);
  endproperty
  a_offc: assert property (p_offc) else $error("offset high byte lost");
endmodule
bind ctot_regs ctot_monitor u_mon (.*);

/* test/ctot_host_model.sv */
/* Host software model issuing single register accesses.
   Assumes the bank clock; calibration is idle throughout. */
`timescale 1ns/1ps
module ctot_host_model
  import ctot_pkg::*;
(
  input  wire logic          clk_i,
  output ctot_pkg::ctot_req_s req_o
);
  initial req_o = '0;
  // Offsets are only touched with calibration idle, so any access is legal
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{a, d, w, !w};
    @(posedge clk_i);
    req_o <= '0;
  endtask
endmodule

/* test/ctot_regs_tb.sv */
/* Self-checking bench for the trim bank.
   Assumes the host model drives the port and a fixed fuse image. */
`timescale 1ns/1ps
module ctot_regs_tb;
  import ctot_pkg::*;
  logic        clk_sys_i = 0;
  logic        sys_rst_i = 1;
  logic        dual_channel_i = 0;
  logic        trim_loaded_o;
  logic [7:0]  rdata_o, spare_timing_o, core_b_timing_o;
  ctot_req_s   req_i;
  ctot_trim_s  trim_o;
  ctot_fuse_s  fuse_i = {8'h11, 8'h22, 12'h333, 12'h444, 12'h555};
  int          miscompares = 0;
  int          num_checks = 0;
  logic [19:0] rows [8] = '{20'h088A5, 20'h0895A, 20'h08A34, 20'h08BF2,
                            20'h08CC3, 20'h08D1E, 20'h08E7F, 20'h08F09};
  ctot_host_model u_host (.clk_i(clk_sys_i), .req_o(req_i));
  ctot_regs u_dut (.*);
  task automatic chk(input string n, input logic [55:0] s, input logic [55:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic results;
    if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  initial begin
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 0;
    for (int i = 0; i < 4 && trim_loaded_o !== 1'b1; i++) @(posedge clk_sys_i);
    #1 chk("loaded", trim_loaded_o, 1);
    if (miscompares != 0) results();
    chk("fuse", trim_o, fuse_i);
    u_host.acc(0, 12'h08B, 0);
    #1 chk("reserved", rdata_o, 8'h03);
    u_host.acc(0, 12'h090, 0);
    #1 chk("unmapped", rdata_o, 0);
    foreach (rows[i]) begin
      u_host.acc(1, rows[i][19:8], rows[i][7:0]);
      u_host.acc(0, rows[i][19:8], 0);
      #1 chk("readback", rdata_o, rows[i][7:0]);
    end
    chk("trims", trim_o, {8'hA5, 8'h5A, 12'h234, 12'hEC3, 12'h97F});
    chk("gated", {spare_timing_o, core_b_timing_o}, 0);
    @(posedge clk_sys_i) dual_channel_i <= 1;
    #1 chk("dual", {spare_timing_o, core_b_timing_o}, 16'hA55A);
    // Mid-run reset must clear the bank, then reload the factory image
    @(posedge clk_sys_i) sys_rst_i <= 1'b1;
    #1 chk("rst_trims", trim_o, 56'h0);
    chk("rst_loaded", trim_loaded_o, 1'b0);
    @(posedge clk_sys_i) sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1 chk("reload", trim_o, fuse_i);
    chk("reloaded", trim_loaded_o, 1'b1);
    results();
  end
endmodule
